// >>> rtl/ee_i2c_eeprom.sv
// Two-wire serial EEPROM target: bus protocol, array with error correction,
// write buffer and self-timed write cycle.
// Assumes a free-running core clock far faster than the bus clock; all bus
// pins arrive asynchronously and the bench resolves the open-drain wire.
`timescale 1ns/1ps
`include "ee_params.svh"

// Behaviour
// - The array holds 262,144 bytes, addressed by an 18-bit byte address.
// - Bus clocks up to 100 kHz, 400 kHz and 1 MHz are all handled correctly.
// - Page writes of up to 256 bytes are accepted, as are single and partial writes.
// - Programming runs on internal timing after the write ends and finishes within 10 ms.
// - Random reads at a host address and sequential reads of consecutive bytes work.
// - Stored data carries error correction so reads return corrected bytes.
// - Command and write data bits are captured on the rising bus clock edge.
// - Read data on the data line changes only on the falling bus clock edge.
// - The data line is open drain: the device only pulls low or releases it.
// - A high write-protect input blocks all writes; a low one lets them proceed.
// - The device answers only when its address strap matches the host's bit.
// - An undriven address strap or write-protect input is not pulled low; only reset loads their synchronizers low.
module ee_i2c_eeprom
  import ee_pkg::*;
#(
  parameter int WRITE_CYCLES = `EE_TWR_CYCLES
) (
  // Core clock and reset.
  input  wire logic I_CORE_CLK,
  input  wire logic I_NRST,
  // Two-wire bus pins.
  input  wire logic I_SCL,
  input  wire logic I_SDA,
  output logic      O_SDA_OUT,
  output logic      O_SDA_OE,
  // Strap and protection pins.
  input  wire logic I_ADDRESS_STRAP_INPUT,
  input  wire logic I_WRITE_PROTECT,
  // Status.
  output logic      O_WRITE_BUSY
);

  // Array word: data byte above four check bits.
  logic [`EE_CODE_W-1:0] mem [0:`EE_MEM_DEPTH-1];

  logic [1:0]                scl_sync_reg;
  logic [1:0]                sda_sync_reg;
  logic [1:0]                strap_sync_reg;
  logic [1:0]                wp_sync_reg;
  logic                      scl_prev_reg;
  logic                      sda_prev_reg;
  ee_state_t                 state_reg;
  logic [3:0]                bit_cnt_reg;
  logic [7:0]                shift_reg;
  logic [7:0]                tx_reg;
  logic [`EE_ADDR_W-1:0]     addr_reg;
  logic                      host_ack_reg;
  logic                      first_rd_reg;
  logic                      wrote_reg;
  logic                      sda_oe_reg;
  logic                      sda_out_reg;
  logic                      busy_reg;
  logic [`EE_BUSY_CNT_W-1:0] busy_cnt_reg;

  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  logic                      wr_push;
  logic                      wr_ready;
  ee_wr_t                    wr_word;
  logic                      drain_valid;
  logic                      drain_ready;
  ee_wr_t                    drain_word;
  logic                      rd_fetch;
  logic [7:0]                rd_byte;
  logic                      dev_match;

  // Check code of a data bit: distinct, never a single set bit.
  function automatic logic [3:0] ee_bit_code(input int idx);
    case (idx)
      0:       ee_bit_code = 4'h3;
      1:       ee_bit_code = 4'h5;
      2:       ee_bit_code = 4'h6;
      3:       ee_bit_code = 4'h7;
      4:       ee_bit_code = 4'h9;
      5:       ee_bit_code = 4'hA;
      6:       ee_bit_code = 4'hB;
      default: ee_bit_code = 4'hC;
    endcase
  endfunction

  // Check bits of a byte.
  function automatic logic [3:0] ee_check(input logic [7:0] d);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (d[i]) begin
        p = p ^ ee_bit_code(i);
      end
    end
    return p;
  endfunction

  // Codeword to store for a byte.
  function automatic logic [`EE_CODE_W-1:0] ee_encode(input logic [7:0] d);
    return {d, ee_check(d)};
  endfunction

  // Corrects any single flipped data bit; a flipped check bit is harmless.
  function automatic logic [7:0] ee_decode(input logic [`EE_CODE_W-1:0] cw);
    logic [3:0] syn;
    logic [7:0] d;
    d   = cw[11:4];
    syn = cw[3:0] ^ ee_check(cw[11:4]);
    for (int i = 0; i < 8; i++) begin
      if (syn == ee_bit_code(i)) begin
        d[i] = ~d[i];
      end
    end
    return d;
  endfunction

  // Next address: writes roll over inside the page, reads run through the array.
  function automatic logic [`EE_ADDR_W-1:0] ee_step(input logic [`EE_ADDR_W-1:0] a,
                                                    input logic in_page);
    logic [`EE_ADDR_W-1:0] n;
    n = a + 1'b1;
    if (in_page) begin
      n = (a & ~`EE_PAGE_MASK) | (n & `EE_PAGE_MASK);
    end
    return n;
  endfunction

  // Two flip-flops on every pin; only the second stage is read.
  // The core clock is 50 times the fastest bus clock, so edges are never missed.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      scl_sync_reg   <= 2'h3;
      sda_sync_reg   <= 2'h3;
      strap_sync_reg <= 2'h0;
      wp_sync_reg    <= 2'h0;
      scl_prev_reg   <= 1'b1;
      sda_prev_reg   <= 1'b1;
    end else begin
      scl_sync_reg   <= {scl_sync_reg[0], I_SCL};
      sda_sync_reg   <= {sda_sync_reg[0], I_SDA};
      strap_sync_reg <= {strap_sync_reg[0], I_ADDRESS_STRAP_INPUT};
      wp_sync_reg    <= {wp_sync_reg[0], I_WRITE_PROTECT};
      scl_prev_reg   <= scl_sync_reg[1];
      sda_prev_reg   <= sda_sync_reg[1];
    end
  end

  // Bus events; start and stop need the clock high on both samples.
  // Reset leaves the clock high, so an idle bus shows no false edge.
  assign scl_rise  = scl_sync_reg[1] & ~scl_prev_reg;
  assign scl_fall  = ~scl_sync_reg[1] & scl_prev_reg;
  assign start_det = scl_prev_reg & scl_sync_reg[1] & sda_prev_reg & ~sda_sync_reg[1];
  assign stop_det  = scl_prev_reg & scl_sync_reg[1] & ~sda_prev_reg & sda_sync_reg[1];

  // Device select: type code, strap bit, and not while programming.
  // Nothing pulls an undriven strap low at the pin; a low strap needs a zero bit.
  assign dev_match = (shift_reg[7:4] == `EE_DEV_TYPE)
                   & (shift_reg[3] == strap_sync_reg[1])
                   & ~busy_reg;

  // A byte is buffered only when unprotected and the buffer has room.
  assign wr_push  = scl_fall & (state_reg == EE_WDATA) & (bit_cnt_reg == `EE_ACK_BIT)
                  & ~wp_sync_reg[1] & wr_ready;
  assign wr_word  = '{addr: addr_reg, data: shift_reg};

  // A read fetch takes the array port, so the drain waits that cycle.
  assign rd_fetch    = scl_fall & (state_reg == EE_RDATA) & (bit_cnt_reg == 4'h0)
                     & (first_rd_reg | host_ack_reg);
  assign rd_byte     = ee_decode(mem[addr_reg]);
  assign drain_ready = ~rd_fetch;

  // Write buffer between the bus and the array.
  ee_fifo #(
    .WIDTH ($bits(ee_wr_t)),
    .DEPTH (`EE_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk       (I_CORE_CLK),
    .i_nrst      (I_NRST),
    .i_in_valid  (wr_push),
    .i_in_data   (wr_word),
    .o_in_ready  (wr_ready),
    .o_out_valid (drain_valid),
    .o_out_data  (drain_word),
    .i_out_ready (drain_ready)
  );

  // Array programming from the buffer, with check bits added.
  always_ff @(posedge I_CORE_CLK) begin
    if (drain_valid && drain_ready) begin
      mem[drain_word.addr] <= ee_encode(drain_word.data);
    end
  end

  // Self-timed write cycle: starts at the stop that ends a write and holds
  // off new accesses until the full time has run and the buffer is empty.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (!busy_reg) begin
      if (stop_det && wrote_reg) begin
        busy_reg     <= 1'b1;
        busy_cnt_reg <= '0;
      end
    end else if (busy_cnt_reg >= `EE_BUSY_CNT_W'(WRITE_CYCLES - 1)) begin
      if (!drain_valid) begin
        busy_reg <= 1'b0;
      end
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 1'b1;
    end
  end

  // Bit capture on rising clock edges; the ninth rise samples the host's answer.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      host_ack_reg <= 1'b0;
    end else if (start_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && state_reg != EE_IDLE) begin
      if (bit_cnt_reg == `EE_ACK_BIT) begin
        host_ack_reg <= ~sda_sync_reg[1];
        bit_cnt_reg  <= 4'h0;
      end else begin
        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
    end
  end

  // Protocol and data-line drive. The line is only ever moved on a falling
  // clock edge, so the host never sees it change while the clock is high.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_reg    <= EE_IDLE;
      addr_reg     <= '0;
      tx_reg       <= 8'h00;
      first_rd_reg <= 1'b0;
      wrote_reg    <= 1'b0;
      sda_oe_reg   <= 1'b0;
      sda_out_reg  <= 1'b0;
    end else if (start_det) begin
      state_reg  <= EE_DEV;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= EE_IDLE;
      sda_oe_reg <= 1'b0;
      wrote_reg  <= 1'b0;
    end else if (scl_fall) begin
      case (state_reg)
        EE_DEV: begin
          if (bit_cnt_reg == `EE_ACK_BIT) begin
            if (dev_match) begin
              addr_reg[17:16] <= shift_reg[2:1];
              sda_oe_reg      <= 1'b1;
              first_rd_reg    <= shift_reg[0];
              state_reg       <= shift_reg[0] ? EE_RDATA : EE_ADDR_HI;
            end else begin
              state_reg <= EE_IGNORE;
            end
          end
        end
        EE_ADDR_HI, EE_ADDR_LO: begin
          if (bit_cnt_reg == `EE_ACK_BIT) begin
            if (state_reg == EE_ADDR_HI) begin
              addr_reg[15:8] <= shift_reg;
              state_reg      <= EE_ADDR_LO;
            end else begin
              addr_reg[7:0] <= shift_reg;
              state_reg     <= EE_WDATA;
            end
            sda_oe_reg <= 1'b1;
          end else if (bit_cnt_reg == 4'h0) begin
            sda_oe_reg <= 1'b0;
          end
        end
        EE_WDATA: begin
          if (bit_cnt_reg == `EE_ACK_BIT) begin
            if (wr_push) begin
              addr_reg   <= ee_step(addr_reg, 1'b1);
              wrote_reg  <= 1'b1;
              sda_oe_reg <= 1'b1;
            end
          end else if (bit_cnt_reg == 4'h0) begin
            sda_oe_reg <= 1'b0;
          end
        end
        EE_RDATA: begin
          if (bit_cnt_reg == 4'h0) begin
            if (rd_fetch) begin
              tx_reg       <= rd_byte;
              sda_oe_reg   <= ~rd_byte[7];
              addr_reg     <= ee_step(addr_reg, 1'b0);
              first_rd_reg <= 1'b0;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= EE_IGNORE;
            end
          end else if (bit_cnt_reg == `EE_ACK_BIT) begin
            sda_oe_reg <= 1'b0;
          end else begin
            sda_oe_reg <= ~tx_reg[3'h7 - bit_cnt_reg[2:0]];
          end
        end
        EE_IGNORE, EE_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        default: begin
          state_reg  <= EE_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Pin drivers: the output level is always low, only the enable moves.
  assign O_SDA_OUT    = sda_out_reg;
  assign O_SDA_OE     = sda_oe_reg;
  assign O_WRITE_BUSY = busy_reg;

endmodule

// >>> rtl/ee_params.svh
// Constants of the two-wire EEPROM target: array size, timing and framing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH
`define EE_MEM_DEPTH     262144
`define EE_ADDR_W        18
`define EE_DATA_W        8
`define EE_ECC_W         4
`define EE_CODE_W        12
`define EE_PAGE_MASK     18'h000FF
`define EE_DEV_TYPE      4'hA
`define EE_FIFO_DEPTH    32
`define EE_CORE_HZ       50000000
`define EE_TWR_MS        10
`define EE_TWR_CYCLES    ((`EE_TWR_MS * `EE_CORE_HZ) / 1000)
`define EE_BUSY_CNT_W    20
`define EE_ACK_BIT       4'h8
`endif

// >>> rtl/ee_pkg.sv
// Types shared by the two-wire EEPROM target and its write buffer.
// Assumes ee_params.svh is on the include path.
`include "ee_params.svh"
package ee_pkg;

  // One buffered write: array address and the byte to store.
  typedef struct packed {
    logic [`EE_ADDR_W-1:0] addr;
    logic [`EE_DATA_W-1:0] data;
  } ee_wr_t;

  // Protocol states, Gray coded along start, address, data.
  typedef enum logic [2:0] {
    EE_IDLE    = 3'h0,
    EE_DEV     = 3'h1,
    EE_ADDR_HI = 3'h3,
    EE_ADDR_LO = 3'h2,
    EE_WDATA   = 3'h6,
    EE_RDATA   = 3'h7,
    EE_IGNORE  = 3'h5
  } ee_state_t;

endpackage

// >>> rtl/ee_fifo.sv
// Synchronous FIFO with valid/ready on both sides, used as the write buffer.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module ee_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Filling side.
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Draining side.
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = store[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Storage has no reset; only the pointers and occupancy count carry control state.
  always_ff @(posedge i_clk) begin
    if (push) begin
      store[wr_ptr_reg] <= i_in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// >>> sim/ee_i2c_eeprom_assertions.sv
// Checker of the EEPROM target pins: data drive timing, busy period, protection.
// Assumes it is bound to ee_i2c_eeprom and sees only that module's ports.
`timescale 1ns/1ps
module ee_i2c_eeprom_chk #(
  parameter int WRITE_CYCLES = 200
) (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_NRST,
  // Bus, straps and status.
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic I_ADDRESS_STRAP_INPUT,
  input wire logic I_WRITE_PROTECT,
  input wire logic O_WRITE_BUSY
);
  localparam int WP_SAT = 4000;
  logic [19:0] busy_cnt_reg;
  logic [12:0] wp_cnt_reg;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  // Length of the running busy period; a short write cycle shows here.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy_cnt_reg <= 20'h0;
    end else begin
      busy_cnt_reg <= O_WRITE_BUSY ? busy_cnt_reg + 20'h1 : 20'h0;
    end
  end
  // Cycles with protection held high; saturates so it never wraps.
  always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      wp_cnt_reg <= 13'h0;
    end else if (!I_WRITE_PROTECT) begin
      wp_cnt_reg <= 13'h0;
    end else if (wp_cnt_reg != 13'(WP_SAT)) begin
      wp_cnt_reg <= wp_cnt_reg + 13'h1;
    end
  end
  sequence s_scl_fell;
    !$past(I_SCL, 3) && ($past(I_SCL, 4) || $past(I_SCL, 5));
  endsequence
  sequence s_scl_low;
    !$past(I_SCL, 3) || !$past(I_SCL, 4);
  endsequence
  sequence s_sda_edge;
    ($past(I_SDA, 3) != $past(I_SDA, 4)) || ($past(I_SDA, 4) != $past(I_SDA, 5));
  endsequence
  a_open_drain: assert property (O_SDA_OUT == 1'b0)
    else $error("data output level is not low");
  a_oe_after_fall: assert property ($rose(O_SDA_OE) |-> s_scl_fell)
    else $error("data pull-down began away from a clock fall");
  a_oe_scl_low: assert property ($changed(O_SDA_OE) |-> s_scl_low or s_sda_edge)
    else $error("data drive changed while the clock was high");
  a_reset_quiet: assert property ($rose(I_NRST) |-> !O_SDA_OE && !O_WRITE_BUSY)
    else $error("outputs active right after reset");
  a_busy_min: assert property ($fell(O_WRITE_BUSY) |-> busy_cnt_reg >= WRITE_CYCLES)
    else $error("write cycle ended too early");
  a_busy_max: assert property (busy_cnt_reg <= WRITE_CYCLES + 64)
    else $error("write cycle ran too long");
  a_busy_no_ack: assert property (O_WRITE_BUSY && $past(O_WRITE_BUSY) |-> !$rose(O_SDA_OE))
    else $error("acknowledge given while busy");
  a_wp_no_write: assert property (wp_cnt_reg == 13'(WP_SAT) |-> !$rose(O_WRITE_BUSY))
    else $error("write cycle started under protection");
endmodule
bind ee_i2c_eeprom ee_i2c_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST), .I_SCL(I_SCL), .I_SDA(I_SDA),
  .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .I_ADDRESS_STRAP_INPUT(I_ADDRESS_STRAP_INPUT),
  .I_WRITE_PROTECT(I_WRITE_PROTECT), .O_WRITE_BUSY(O_WRITE_BUSY));

// >>> sim/ee_host_model.sv
// Two-wire bus host model: drives the bus clock and pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up and calls its tasks.
`timescale 1ns/1ps
module ee_host_model (
  // Time base.
  input  wire logic i_clk,
  // Resolved data wire.
  input  wire logic i_sda,
  // Bus clock and data pull-down.
  output logic      o_scl,
  output logic      o_sda_low
);
  int slow = 1;
  // Both lines released while the bus is idle.
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n * slow) @(posedge i_clk);
  endtask
  // One bit: data set while the clock is low, read at the end of the high phase.
  task automatic bit_io(input logic b, output logic r);
    wt(1);
    o_sda_low <= ~b;
    wt(3);
    o_scl <= 1'b1;
    wt(4);
    r = i_sda;
    o_scl <= 1'b0;
  endtask
  // Start, or repeated start with a longer low phase so the target can let go.
  task automatic start();
    // The clock fall that ended the last bit is still pending when this task is
    // called in the same time step, so wait one step before testing the level.
    wt(1);
    if (!o_scl) begin
      wt(1);
      o_sda_low <= 1'b0;
      wt(4);
      o_scl <= 1'b1;
    end
    wt(4);
    o_sda_low <= 1'b1;
    wt(4);
    o_scl <= 1'b0;
  endtask
  // Stop, then clock stands high.
  task automatic stop();
    wt(1);
    o_sda_low <= 1'b1;
    wt(3);
    o_scl <= 1'b1;
    wt(4);
    o_sda_low <= 1'b0;
    wt(8);
  endtask
  // Eight bits MSB first plus the acknowledge slot.
  task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                         output logic ack_seen);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, r);
    ack_seen = ~r;
  endtask
endmodule

// >>> sim/ee_i2c_eeprom_tb.sv
// Bench of the EEPROM target: random page writes, reads, polling, straps, protection.
// Assumes the host model drives the bus and the data wire has a pull-up.
`timescale 1ns/1ps
`include "ee_params.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", nm, ex, got); end end
module ee_i2c_eeprom_tb;
  logic        clk, nrst, strap, wp, sda, scl, sda_low, oe, busy;
  logic [17:0] a;
  logic [7:0]  mem [logic [17:0]];
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          seed      = 32'hb606b8ee;
  // Open-drain wire: low while either party pulls, else the pull-up wins.
  assign sda = ~(oe | sda_low);
  ee_i2c_eeprom #(.WRITE_CYCLES(200)) u_dut (
    .I_CORE_CLK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(),
    .O_SDA_OE(oe), .I_ADDRESS_STRAP_INPUT(strap), .I_WRITE_PROTECT(wp), .O_WRITE_BUSY(busy));
  ee_host_model u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // Select byte: type code, strap, top address bits, direction.
  function automatic logic [7:0] hdr(input logic [17:0] ad, input logic s, input logic r);
    return {`EE_DEV_TYPE, s, ad[17:16], r};
  endfunction
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Byte sent with the target's acknowledge compared.
  task automatic xb(input logic [7:0] d, input logic ex);
    logic [7:0] q;
    logic       ack;
    u_host.byte_io(d, 1'b1, q, ack);
    `CHK("ack", ex, ack)
  endtask
  task automatic set_addr(input logic [17:0] ad);
    u_host.start();
    xb(hdr(ad, strap, 1'b0), 1'b1);
    xb(ad[15:8], 1'b1);
    xb(ad[7:0], 1'b1);
  endtask
  // Polls until acknowledged; a busy target must refuse the first one.
  task automatic poll();
    logic [7:0] q;
    logic       ack;
    int         k;
    k = 0;
    do begin
      u_host.start();
      u_host.byte_io(hdr(18'h0, strap, 1'b0), 1'b1, q, ack);
      u_host.stop();
      k++;
    end while (!ack && k < 60);
    `CHK("poll_refused", !wp, k > 1)
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic wr(input logic [17:0] ad, input int n);
    logic [7:0] d;
    set_addr(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      xb(d, ~wp);
      if (!wp) begin
        mem[ad] = d;
        ad = {ad[17:8], ad[7:0] + 8'h01};
      end
    end
    u_host.stop();
    poll();
  endtask
  // Random read, then sequential bytes, compared where the model knows them.
  task automatic rd(input logic [17:0] ad, input int n);
    logic [7:0] q;
    logic       ack;
    set_addr(ad);
    u_host.start();
    xb(hdr(ad, strap, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.byte_io(8'hFF, i == n - 1, q, ack);
      if (mem.exists(ad)) `CHK("rdata", mem[ad], q)
      ad = ad + 18'h1;
    end
    u_host.stop();
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Watchdog well above the expected run length.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    final_report();
  end
  // Main sequence.
  initial begin
    nrst  = 1'b0;
    strap = 1'b0;
    wp    = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    for (int t = 0; t < 6; t++) begin
      a = 18'($random(seed));
      if (t == 0) a[7:0] = 8'hFC; // Full burst wraps inside the page.
      strap <= t[0];
      repeat (4) @(posedge clk);
      wr(a, (t == 0) ? 8 : 1 + ($random(seed) & 7));
      rd(a, 8);
      rd({a[17:8], 8'h00}, 4);
      u_host.start();
      xb(hdr(a, ~strap, 1'b0), 1'b0);
      u_host.stop();
    end
    wr(18'h3FFFF, 1);
    wr(18'h00000, 1);
    rd(18'h3FFFF, 2);
    u_host.slow = 8;
    rd(a, 4);
    u_host.slow = 1;
    wp <= 1'b1;
    repeat (4100) @(posedge clk);
    wr(a, 3);
    rd(a, 3);
    wp <= 1'b0;
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    rd(a, 4);
    final_report();
  end
endmodule
